//--- pkg/xcvr_pkg.sv
// Shared constants for the transceiver control block and its host controller
// Assumes one 20 MHz clock mclk and a synchronous active-low reset
package xcvr_pkg;
  // ---------------------------------------------------------------
  // Two-wire addressing and diagnostic page layout
  // ---------------------------------------------------------------
  localparam logic [7:0] ID_DEV_ADDR = 8'hA0;
  localparam logic [7:0] DIAG_DEV_ADDR = 8'hA2;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] CTRL_STATUS_OFS = 8'h6E;
  localparam int TXD_STATE_BIT = 7;
  localparam int SOFT_TXD_BIT = 6;
  localparam int FAULT_BIT = 2;
  localparam int LOS_BIT = 1;
  localparam logic [7:0] MON_BASE = 8'h60;
  localparam int MON_W = 16;
  localparam int MON_COUNT = 5;
  localparam logic [7:0] MON_BYTES = 8'h0A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ---------------------------------------------------------------
  // Host register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;
  localparam int CTRL_TXD_BIT = 0;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_PAGE_BIT = 16;
  localparam int CMD_READ_BIT = 17;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_NACK_BIT = 9;
  localparam int STAT_TXD_BIT = 10;
  localparam int STAT_LOS_BIT = 11;
  localparam int STAT_FAULT_BIT = 12;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_NACK_BIT = 1;
  localparam int IRQ_FAULT_BIT = 2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int TXD_GAP_MS = 10;
  localparam int TXD_GAP_CYCLES = (TXD_GAP_MS * (CLK_HZ / 1000));
  localparam int SCL_QUARTER_CYCLES = 50;
  // ---------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RXB = 3'b001,
    S_ACK = 3'b010,
    S_TXB = 3'b011,
    S_MACK = 3'b100
  } slv_state_e;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_STA = 2'b01,
    M_BITS = 2'b10,
    M_STP = 2'b11
  } mst_state_e;
endpackage

//--- pkg/xcvr_if.sv
// Pins between the transceiver and the host board
// Assumes pull-ups on the two-wire lines, the fault line and the disable input
interface xcvr_if;
  // ---------------------------------------------------------------
  // Driver side signals
  // ---------------------------------------------------------------
  logic scl_o_h;
  logic scl_oe_h;
  logic sda_o_h;
  logic sda_oe_h;
  logic sda_o_d;
  logic sda_oe_d;
  logic txd_o;
  logic txd_oe;
  logic fault_o;
  logic fault_oe;
  logic los;
  // ---------------------------------------------------------------
  // Resolved wire levels
  // ---------------------------------------------------------------
  logic scl;
  logic sda;
  logic txd;
  logic fault;
  assign scl = ~(scl_oe_h & ~scl_o_h);
  assign sda = ~((sda_oe_h & ~sda_o_h) | (sda_oe_d & ~sda_o_d));
  assign txd = txd_oe ? txd_o : 1'b1;
  assign fault = ~(fault_oe & ~fault_o);
  modport dev (input scl, input sda, input txd, output sda_o_d, output sda_oe_d,
    output fault_o, output fault_oe, output los);
  modport host (input sda, input fault, input los, output scl_o_h, output scl_oe_h,
    output sda_o_h, output sda_oe_h, output txd_o, output txd_oe);
endinterface

//--- rtl/xcvr_device.sv
// Transceiver side: disable, fault latch, loss of signal and two-wire pages
// Assumes pin inputs are asynchronous to mclk; detector inputs are on mclk
module xcvr_device #(
  parameter logic [15:0] LOS_THRESHOLD = 16'h0100
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins to the host board
  xcvr_if.dev link,
  // Laser supervision
  input wire logic laser_fault_det,
  input wire logic eye_unsafe_det,
  // Monitor readings
  input wire logic [xcvr_pkg::MON_W-1:0] temp_mon,
  input wire logic [xcvr_pkg::MON_W-1:0] vcc_mon,
  input wire logic [xcvr_pkg::MON_W-1:0] bias_mon,
  input wire logic [xcvr_pkg::MON_W-1:0] txpwr_mon,
  input wire logic [xcvr_pkg::MON_W-1:0] rxpwr_mon,
  // Laser control
  output logic laser_enable
);
  import xcvr_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] scl_sy_reg;
  logic [2:0] sda_sy_reg;
  logic [2:0] txd_sy_reg;
  logic scl_reg;
  logic sda_reg;
  logic txd_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic txd_prev_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sy_reg <= 3'h7;
      sda_sy_reg <= 3'h7;
      txd_sy_reg <= 3'h7;
    end else begin
      scl_sy_reg <= {scl_sy_reg[1:0], link.scl};
      sda_sy_reg <= {sda_sy_reg[1:0], link.sda};
      txd_sy_reg <= {txd_sy_reg[1:0], link.txd};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      txd_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      txd_prev_reg <= 1'b1;
    end else begin
      if (scl_sy_reg[2] == scl_sy_reg[1]) scl_reg <= scl_sy_reg[2];
      if (sda_sy_reg[2] == sda_sy_reg[1]) sda_reg <= sda_sy_reg[2];
      if (txd_sy_reg[2] == txd_sy_reg[1]) txd_reg <= txd_sy_reg[2];
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
      txd_prev_reg <= txd_reg;
    end
  end

  // ---------------------------------------------------------------
  // Bus conditions
  // ---------------------------------------------------------------
  wire scl_rise = scl_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_reg & scl_prev_reg;
  wire start_ev = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  wire stop_ev = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
  wire txd_fall = txd_prev_reg & ~txd_reg;

  // ---------------------------------------------------------------
  // Disable, fault and loss-of-signal state
  // ---------------------------------------------------------------
  logic soft_txd_reg;
  logic fault_reg;
  logic los_reg;
  logic laser_en_reg;
  logic fault_oe_reg;
  wire txd_state = txd_reg | soft_txd_reg;
  wire fault_set = laser_fault_det | eye_unsafe_det;
  wire fault_next = fault_set | (fault_reg & ~txd_fall);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_reg <= 1'b0;
      fault_oe_reg <= 1'b1;
      los_reg <= 1'b1;
      laser_en_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      fault_oe_reg <= ~fault_next;
      los_reg <= (rxpwr_mon < LOS_THRESHOLD);
      laser_en_reg <= ~(txd_state | fault_next);
    end
  end

  assign laser_enable = laser_en_reg;
  assign link.fault_o = 1'b0;
  assign link.fault_oe = fault_oe_reg;
  assign link.los = los_reg;

  // ---------------------------------------------------------------
  // Page contents and read selection
  // ---------------------------------------------------------------
  logic [7:0] id_mem [PAGE_BYTES];
  logic [7:0] diag_mem [PAGE_BYTES];
  logic [7:0] mon_bytes [MON_COUNT*2];
  logic [7:0] ptr_reg;
  logic page_reg;
  logic [MON_W*MON_COUNT-1:0] mon_vec;
  assign mon_vec = {temp_mon, vcc_mon, bias_mon, txpwr_mon, rxpwr_mon};

  genvar g;
  generate
    for (g = 0; g < MON_COUNT * 2; g++) begin : g_mon
      assign mon_bytes[g] = mon_vec[(MON_COUNT*2-1-g)*8 +: 8];
    end
  endgenerate

  wire [7:0] mon_idx = ptr_reg - MON_BASE;
  wire in_mon = (ptr_reg >= MON_BASE) && (mon_idx < MON_BYTES);
  wire [7:0] mon_byte = in_mon ? mon_bytes[mon_idx[3:0]] : 8'h00;
  wire [7:0] status_byte = (8'(txd_state) << TXD_STATE_BIT)
    | (8'(soft_txd_reg) << SOFT_TXD_BIT)
    | (8'(fault_reg) << FAULT_BIT)
    | (8'(los_reg) << LOS_BIT);
  wire [7:0] rd_byte = !page_reg ? id_mem[ptr_reg]
    : (ptr_reg == CTRL_STATUS_OFS) ? status_byte
    : in_mon ? mon_byte : diag_mem[ptr_reg];

  // ---------------------------------------------------------------
  // Two-wire slave
  // ---------------------------------------------------------------
  slv_state_e st_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [1:0] bnum_reg;
  logic rw_reg;
  logic mack_reg;
  logic sda_oe_reg;
  wire byte_in = (st_reg == S_RXB) && (cnt_reg == BITS_PER_BYTE);
  wire addr_hit = (sh_reg[7:1] == ID_DEV_ADDR[7:1])
    || (sh_reg[7:1] == DIAG_DEV_ADDR[7:1]);
  wire mem_we = scl_fall & byte_in & (bnum_reg == 2'h2);
  wire ctl_we = mem_we & page_reg & (ptr_reg == CTRL_STATUS_OFS);
  wire sda_drive = (st_reg == S_ACK) || ((st_reg == S_TXB) && !sh_reg[7]);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      bnum_reg <= 2'h0;
      rw_reg <= 1'b0;
      page_reg <= 1'b0;
      ptr_reg <= 8'h00;
      mack_reg <= 1'b0;
    end else if (stop_ev) begin
      st_reg <= S_IDLE;
    end else if (start_ev) begin
      st_reg <= S_RXB;
      cnt_reg <= 4'h0;
      bnum_reg <= 2'h0;
    end else if (scl_rise) begin
      if (st_reg == S_RXB) begin
        sh_reg <= {sh_reg[6:0], sda_reg};
        cnt_reg <= cnt_reg + 4'h1;
      end
      if (st_reg == S_TXB) cnt_reg <= cnt_reg + 4'h1;
      if (st_reg == S_MACK) mack_reg <= ~sda_reg;
    end else if (scl_fall) begin
      case (st_reg)
        S_RXB: begin
          if (byte_in) begin
            st_reg <= (bnum_reg == 2'h0 && !addr_hit) ? S_IDLE : S_ACK;
            if (bnum_reg == 2'h0) begin
              page_reg <= sh_reg[1];
              rw_reg <= sh_reg[0];
            end
            if (bnum_reg == 2'h1) ptr_reg <= sh_reg;
            if (bnum_reg == 2'h2) ptr_reg <= ptr_reg + 8'h01;
          end
        end
        S_ACK: begin
          cnt_reg <= 4'h0;
          if (rw_reg) begin
            st_reg <= S_TXB;
            sh_reg <= rd_byte;
            ptr_reg <= ptr_reg + 8'h01;
          end else begin
            st_reg <= S_RXB;
            if (bnum_reg != 2'h2) bnum_reg <= bnum_reg + 2'h1;
          end
        end
        S_TXB: begin
          if (cnt_reg == BITS_PER_BYTE) st_reg <= S_MACK;
          else sh_reg <= {sh_reg[6:0], 1'b0};
        end
        S_MACK: begin
          if (mack_reg) begin
            st_reg <= S_TXB;
            cnt_reg <= 4'h0;
            sh_reg <= rd_byte;
            ptr_reg <= ptr_reg + 8'h01;
          end else begin
            st_reg <= S_IDLE;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) sda_oe_reg <= 1'b0;
    else sda_oe_reg <= sda_drive;
  end

  assign link.sda_o_d = 1'b0;
  assign link.sda_oe_d = sda_oe_reg;

  // ---------------------------------------------------------------
  // Page writes
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (mem_we && !page_reg) id_mem[ptr_reg] <= sh_reg;
    if (mem_we && page_reg) diag_mem[ptr_reg] <= sh_reg;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) soft_txd_reg <= 1'b0;
    else if (ctl_we) soft_txd_reg <= sh_reg[SOFT_TXD_BIT];
  end
endmodule

//--- rtl/xcvr_host.sv
// Host side: AHB-Lite registers, disable pin driver, two-wire master
// Assumes a single AHB-Lite master and a transceiver on the xcvr_if pins
module xcvr_host #(
  parameter int GAP_CYCLES = xcvr_pkg::TXD_GAP_CYCLES,
  parameter int SCL_QUARTER = xcvr_pkg::SCL_QUARTER_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins to the transceiver
  xcvr_if.host link,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq
);
  import xcvr_pkg::*;

  generate
    if (GAP_CYCLES < 1 || GAP_CYCLES >= 2 ** 24 || SCL_QUARTER < 2 || SCL_QUARTER > 255) begin : g_chk
      $error("xcvr_host parameter out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sda_sy_reg;
  logic [2:0] flt_sy_reg;
  logic [2:0] los_sy_reg;
  logic sda_in_reg;
  logic flt_reg;
  logic flt_prev_reg;
  logic los_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sda_sy_reg <= 3'h7;
      flt_sy_reg <= 3'h0;
      los_sy_reg <= 3'h0;
      sda_in_reg <= 1'b1;
      flt_reg <= 1'b0;
      flt_prev_reg <= 1'b0;
      los_reg <= 1'b0;
    end else begin
      sda_sy_reg <= {sda_sy_reg[1:0], link.sda};
      flt_sy_reg <= {flt_sy_reg[1:0], link.fault};
      los_sy_reg <= {los_sy_reg[1:0], link.los};
      if (sda_sy_reg[2] == sda_sy_reg[1]) sda_in_reg <= sda_sy_reg[2];
      if (flt_sy_reg[2] == flt_sy_reg[1]) flt_reg <= flt_sy_reg[2];
      if (los_sy_reg[2] == los_sy_reg[1]) los_reg <= los_sy_reg[2];
      flt_prev_reg <= flt_reg;
    end
  end

  // ---------------------------------------------------------------
  // Bus slave decode
  // ---------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] wa_reg;
  logic ctrl_txd_reg;
  logic busy_reg;
  logic nack_reg;
  logic txd_o_reg;
  logic [7:0] rdata_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  wire addr_ph = hsel & htrans[1] & hready;
  wire wr_ctrl = wr_pend_reg && (wa_reg == CTRL_OFS);
  wire wr_cmd = wr_pend_reg && (wa_reg == CMD_OFS) && !busy_reg;
  wire wr_clr = wr_pend_reg && (wa_reg == IRQ_CLR_OFS);
  wire wr_en = wr_pend_reg && (wa_reg == IRQ_EN_OFS);
  wire [31:0] status_word = {19'h0, flt_reg, los_reg, txd_o_reg, nack_reg, busy_reg, rdata_reg};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux = (ra == CTRL_OFS) ? {31'h0, ctrl_txd_reg}
    : (ra == STATUS_OFS) ? status_word
    : (ra == IRQ_STAT_OFS) ? {29'h0, irq_stat_reg}
    : (ra == IRQ_EN_OFS) ? {29'h0, irq_en_reg} : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_txd_reg <= 1'b0;
      irq_en_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ph & hwrite;
      wa_reg <= ra;
      hrdata <= (addr_ph && !hwrite) ? rd_mux : 32'h0;
      if (wr_ctrl) ctrl_txd_reg <= hwdata[CTRL_TXD_BIT];
      if (wr_en) irq_en_reg <= hwdata[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Disable pin with assertion spacing
  // ---------------------------------------------------------------
  logic [23:0] gap_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txd_o_reg <= 1'b0;
      gap_reg <= 24'h0;
    end else if (!ctrl_txd_reg) begin
      txd_o_reg <= 1'b0;
      if (gap_reg != 24'h0) gap_reg <= gap_reg - 24'h1;
    end else if (!txd_o_reg && gap_reg == 24'h0) begin
      txd_o_reg <= 1'b1;
      gap_reg <= 24'(GAP_CYCLES);
    end else if (gap_reg != 24'h0) begin
      gap_reg <= gap_reg - 24'h1;
    end
  end
  assign link.txd_o = txd_o_reg;
  assign link.txd_oe = rst_n | 1'b1;

  // ---------------------------------------------------------------
  // Two-wire master
  // ---------------------------------------------------------------
  mst_state_e mst_reg;
  logic [7:0] div_reg;
  logic [1:0] q_reg;
  logic [1:0] k_reg;
  logic [3:0] b_reg;
  logic [7:0] rx_reg;
  logic [7:0] c_addr_reg;
  logic [7:0] c_data_reg;
  logic c_page_reg;
  logic c_read_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  wire tick = (div_reg == 8'h00);
  wire [7:0] dev_w = c_page_reg ? DIAG_DEV_ADDR : ID_DEV_ADDR;
  wire [7:0] tx_byte = (k_reg == 2'h0) ? dev_w : (k_reg == 2'h1) ? c_addr_reg
    : c_read_reg ? (dev_w | 8'h01) : c_data_reg;
  wire is_rx = c_read_reg && (k_reg == 2'h3);
  wire last_byte = c_read_reg ? (k_reg == 2'h3) : (k_reg == 2'h2);
  wire tx_bit = tx_byte[3'(4'h7 - b_reg)];
  wire in_byte = (b_reg < BITS_PER_BYTE);
  wire done_ev = tick && (mst_reg == M_STP) && (q_reg == 2'h3);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mst_reg <= M_IDLE;
      div_reg <= 8'h00;
      {q_reg, k_reg, b_reg} <= '0;
      {busy_reg, nack_reg, scl_oe_reg, sda_oe_reg} <= '0;
      {rx_reg, rdata_reg, c_addr_reg, c_data_reg} <= '0;
      {c_page_reg, c_read_reg} <= '0;
    end else if (mst_reg == M_IDLE) begin
      if (wr_cmd) begin
        c_data_reg <= hwdata[CMD_DATA_LSB +: 8];
        c_addr_reg <= hwdata[CMD_ADDR_LSB +: 8];
        c_page_reg <= hwdata[CMD_PAGE_BIT];
        c_read_reg <= hwdata[CMD_READ_BIT];
        {busy_reg, nack_reg, q_reg, k_reg, div_reg} <= '0;
        busy_reg <= 1'b1;
        mst_reg <= M_STA;
      end
    end else begin
      div_reg <= tick ? 8'(SCL_QUARTER - 1) : div_reg - 8'h01;
      if (tick) begin
        q_reg <= q_reg + 2'h1;
        case (mst_reg)
          M_STA: begin
            if (q_reg == 2'h0) sda_oe_reg <= 1'b0;
            if (q_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (q_reg == 2'h2) sda_oe_reg <= 1'b1;
            if (q_reg == 2'h3) begin
              scl_oe_reg <= 1'b1;
              b_reg <= 4'h0;
              mst_reg <= M_BITS;
            end
          end
          M_BITS: begin
            if (q_reg == 2'h0) sda_oe_reg <= !is_rx && in_byte && !tx_bit;
            if (q_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (q_reg == 2'h2 && in_byte) rx_reg <= {rx_reg[6:0], sda_in_reg};
            if (q_reg == 2'h2 && !in_byte && !is_rx && sda_in_reg) nack_reg <= 1'b1;
            if (q_reg == 2'h3) begin
              scl_oe_reg <= 1'b1;
              b_reg <= in_byte ? b_reg + 4'h1 : 4'h0;
              if (!in_byte) begin
                if (nack_reg || last_byte) mst_reg <= M_STP;
                else if (c_read_reg && k_reg == 2'h1) mst_reg <= M_STA;
                if (!last_byte) k_reg <= k_reg + 2'h1;
              end
            end
          end
          M_STP: begin
            if (q_reg == 2'h0) sda_oe_reg <= 1'b1;
            if (q_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (q_reg == 2'h2) sda_oe_reg <= 1'b0;
            if (q_reg == 2'h3) begin
              busy_reg <= 1'b0;
              rdata_reg <= rx_reg;
              mst_reg <= M_IDLE;
            end
          end
          default: mst_reg <= M_IDLE;
        endcase
      end
    end
  end
  assign link.scl_o_h = 1'b0;
  assign link.scl_oe_h = scl_oe_reg;
  assign link.sda_o_h = 1'b0;
  assign link.sda_oe_h = sda_oe_reg;

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  wire [IRQ_W-1:0] ev = {flt_reg & ~flt_prev_reg, done_ev & nack_reg, done_ev};
  wire [IRQ_W-1:0] clr = wr_clr ? hwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_next = (irq_stat_reg & ~clr) | ev;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_next;
      irq <= |(irq_next & irq_en_reg);
    end
  end
endmodule

//--- tb/xcvr_asserts.sv
// Pin checker for the transceiver and host pair
// Assumes instantiation beside the xcvr_if instance, on mclk
module xcvr_asserts #(
  parameter int GAP = 50
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins and laser
  input wire logic scl,
  input wire logic txd,
  input wire logic txd_o,
  input wire logic fault,
  input wire logic fault_o,
  input wire logic sda_oe_d,
  input wire logic laser_enable,
  input wire logic laser_fault_det,
  input wire logic eye_unsafe_det
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Disable spacing counter
  // ---------------------------------------------------------------
  int gap_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n) gap_cnt <= GAP;
    else if ($rose(txd_o)) gap_cnt <= 1;
    else if (gap_cnt < GAP) gap_cnt <= gap_cnt + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  fault_pol_a: assert property (!fault_o && (!fault || !laser_enable))
    else $error("fault output driven high");
  fault_set_a: assert property (laser_fault_det |-> ##[1:2] fault)
    else $error("laser fault not flagged");
  eye_trip_a: assert property (eye_unsafe_det |-> ##[1:2] fault)
    else $error("unsafe power not flagged");
  laser_off_a: assert property (fault [*2] |-> !laser_enable)
    else $error("laser on during fault");
  txd_off_a: assert property (txd [*8] |-> !laser_enable)
    else $error("laser on while disabled");
  fault_hold_a: assert property (fault && txd |=> fault)
    else $error("fault dropped without toggle");
  fault_clr_a: assert property ($fell(fault) |-> !txd && !$past(laser_fault_det))
    else $error("fault cleared without cycle");
  sda_edge_a: assert property ($changed(sda_oe_d) |-> !scl)
    else $error("data changed while clock high");
  txd_gap_a: assert property ($rose(txd_o) |-> gap_cnt >= GAP)
    else $error("disable reasserted too soon");
  cover property ($rose(fault));
  cover property ($fell(fault));
  cover property ($rose(sda_oe_d));
endmodule

//--- tb/transceiver_control_status_test.sv
// Testbench for the transceiver and host pair
// Assumes the package, interface and both design modules
module transceiver_control_status_test;
  timeunit 1ns;
  timeprecision 1ns;
  import xcvr_pkg::*;
  logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic laser_fault_det = 0, eye_unsafe_det = 0, laser_enable;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, s;
  logic [15:0] rxpwr_mon = 16'h0200;
  logic [15:0] temp_mon = 16'h1234, vcc_mon = 16'h3300, bias_mon = 16'h0800;
  logic [15:0] txpwr_mon = 16'h0400;
  logic [2:0] hsize = 3'h2;
  logic [7:0] q;
  int miscompares = 0, checked = 0;
  xcvr_if pins();
  xcvr_device u_xcvr_device (.mclk(mclk), .rst_n(rst_n), .link(pins),
    .laser_fault_det(laser_fault_det), .eye_unsafe_det(eye_unsafe_det),
    .temp_mon(temp_mon), .vcc_mon(vcc_mon), .bias_mon(bias_mon),
    .txpwr_mon(txpwr_mon), .rxpwr_mon(rxpwr_mon), .laser_enable(laser_enable));
  xcvr_host #(.GAP_CYCLES(50), .SCL_QUARTER(4)) u_xcvr_host (.mclk(mclk), .rst_n(rst_n),
    .link(pins), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));
  xcvr_asserts #(.GAP(50)) u_xcvr_asserts (.mclk(mclk), .rst_n(rst_n), .scl(pins.scl),
    .txd(pins.txd), .txd_o(pins.txd_o), .fault(pins.fault), .fault_o(pins.fault_o),
    .sda_oe_d(pins.sda_oe_d), .laser_enable(laser_enable),
    .laser_fault_det(laser_fault_det), .eye_unsafe_det(eye_unsafe_det));
  initial begin
    forever #25 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task wrap_up;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task hw;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 99);
    if (n >= 99) begin
      miscompares++;
      wrap_up;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hw;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    hw;
    s = hrdata;
  endtask
  task cmd(input logic r, input logic pg, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    bus(1, CMD_OFS, {14'h0, r, pg, a, d});
    do begin
      bus(0, STATUS_OFS, 32'h0);
      n++;
    end while (s[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      wrap_up;
    end
    q = s[7:0];
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_txd;
    bus(1, CTRL_OFS, 32'h0);
    tick(12);
    chk(laser_enable, 1);
    bus(1, CTRL_OFS, 32'h1);
    bus(1, CTRL_OFS, 32'h0);
    bus(1, CTRL_OFS, 32'h1);
    tick(5);
    chk(pins.txd, 0);
    tick(60);
    chk(pins.txd, 1);
    chk(laser_enable, 0);
    cmd(1, 1, CTRL_STATUS_OFS, 8'h00);
    chk(q, 8'h80);
    bus(1, CTRL_OFS, 32'h0);
  endtask
  task t_soft;
    cmd(0, 1, CTRL_STATUS_OFS, 8'h40);
    tick(12);
    chk(laser_enable, 0);
    cmd(1, 1, CTRL_STATUS_OFS, 8'h00);
    chk(q, 8'hC0);
    cmd(0, 1, CTRL_STATUS_OFS, 8'h00);
    tick(12);
    chk(laser_enable, 1);
  endtask
  task t_los;
    rxpwr_mon <= 16'h0010;
    tick(4);
    chk(pins.los, 1);
    cmd(1, 1, CTRL_STATUS_OFS, 8'h00);
    chk(q, 8'h02);
    chk(s[STAT_LOS_BIT], 1);
    rxpwr_mon <= 16'h0200;
    tick(4);
    chk(pins.los, 0);
  endtask
  task t_fault(input logic eye);
    bus(1, IRQ_EN_OFS, 32'h4);
    laser_fault_det <= !eye;
    eye_unsafe_det <= eye;
    tick(1);
    laser_fault_det <= 0;
    eye_unsafe_det <= 0;
    tick(8);
    chk(pins.fault, 1);
    chk(laser_enable, 0);
    chk(irq, 1);
    cmd(1, 1, CTRL_STATUS_OFS, 8'h00);
    chk(q, 8'h04);
    chk(pins.fault, 1);
    bus(1, CTRL_OFS, 32'h1);
    tick(8);
    bus(1, CTRL_OFS, 32'h0);
    tick(12);
    chk(pins.fault, 0);
    chk(laser_enable, 1);
    bus(1, IRQ_CLR_OFS, 32'h7);
    tick(1);
    chk(irq, 0);
  endtask
  task t_mem;
    cmd(0, 0, 8'h10, 8'h5A);
    cmd(1, 0, 8'h10, 8'h00);
    chk(q, 8'h5A);
    cmd(1, 1, MON_BASE, 8'h00);
    chk(q, 8'h12);
    bus(0, IRQ_STAT_OFS, 32'h0);
    chk(s[IRQ_DONE_BIT], 1);
    bus(0, 8'h20, 32'h0);
    chk(s, 32'h0);
  endtask
  initial begin
    tick(3);
    rst_n <= 1;
    t_txd;
    t_soft;
    t_los;
    t_fault(0);
    t_fault(1);
    t_mem;
    wrap_up;
  end
endmodule
